//--- shared/dslp_pkg.sv
// Constants shared by the sector layout block: register map, field positions,
// reset values and the per-format overhead figures.
// Assumes a 32-bit APB register bus and byte positions that fit in 16 bits.
package dslp_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DATALEN_OFS = 8'h04;
  localparam logic [7:0] HDRLEN_OFS = 8'h08;
  localparam logic [7:0] CHECKLEN_OFS = 8'h0c;
  localparam logic [7:0] SECCMD_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] SPACING_OFS = 8'h18;

  // Field positions.
  localparam int CTRL_MODEL_LSB = 0;
  localparam int CTRL_FMT_LSB = 2;
  localparam int SECCMD_VALID_BIT = 16;

  // Reset values.
  localparam logic [1:0] MODEL_RST = 2'h0;
  localparam logic [1:0] FMT_RST = 2'h2;
  localparam logic [15:0] DATALEN_RST = 16'h0085;
  localparam logic [15:0] HDRLEN_RST = 16'h0008;
  localparam logic [15:0] CHECKLEN_RST = 16'h0005;

  // Byte budget per track for the two formula families.
  localparam logic [15:0] BUDGET_STD = 16'h5dc0;
  localparam logic [15:0] BUDGET_LARGE = 16'h7d00;

  // Overhead bytes per format, lower-capacity pair then higher-capacity pair.
  localparam logic [15:0] OVHD_F1_LOW = 16'h003b;
  localparam logic [15:0] OVHD_F1_HIGH = 16'h0027;
  localparam logic [15:0] OVHD_F2_LOW = 16'h003c;
  localparam logic [15:0] OVHD_F2_HIGH = 16'h0028;
  localparam logic [15:0] OVHD_F3_LOW = 16'h004b;
  localparam logic [15:0] OVHD_F3_HIGH = 16'h0037;

  // Smallest data field selectable by the sector length switches.
  localparam logic [15:0] SW_BASE_DATA = 16'h0080;

  // Model codes: two lower-capacity models, then two higher-capacity ones.
  typedef enum logic [1:0] {MODEL_A, MODEL_B, MODEL_C, MODEL_D} dslp_model_t;
  // Sector formats; the fourth code is treated as the third format.
  typedef enum logic [1:0] {FMT_ONE, FMT_TWO, FMT_THREE, FMT_SPARE} dslp_fmt_t;

endpackage : dslp_pkg

//--- shared/dslp_div_if.sv
// Request and answer signals between the layout logic and its divider.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface dslp_div_if #(parameter int W = 16);
  logic start;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic done;
  logic [W-1:0] quotient;
  modport req (output start, output dividend, output divisor, input done, input quotient);
  modport div (input start, input dividend, input divisor, output done, output quotient);
endinterface : dslp_div_if
`default_nettype wire

//--- verilog/dslp_divider.sv
// Serial restoring divider, one quotient bit per clock, quotient rounded down.
// Assumes start is a one-cycle pulse and the operands hold until done.
`timescale 1ns/100ps
`default_nettype none
module dslp_divider #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Division port.
  dslp_div_if.div dv
);

  logic [W-1:0] rem_r;
  logic [W-1:0] quo_r;
  logic [$clog2(W+1)-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  wire logic [W:0] remShift;
  wire logic fits;
  wire logic [W:0] remSub;

  // Trial subtraction; the fraction is simply dropped at the end.
  assign remShift = {rem_r, quo_r[W-1]};
  assign fits = remShift >= {1'b0, dv.divisor};
  assign remSub = remShift - {1'b0, dv.divisor};
  assign dv.done = done_r;
  assign dv.quotient = quo_r;

  // One shift-and-subtract step per cycle while busy.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rem_r <= '0;
      quo_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (dv.start) begin
        rem_r <= '0;
        quo_r <= dv.dividend;
        cnt_r <= ($clog2(W+1))'(W);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rem_r <= fits ? remSub[W-1:0] : remShift[W-1:0];
        quo_r <= {quo_r[W-2:0], fits};
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

endmodule : dslp_divider
`default_nettype wire

//--- verilog/disk_sector_layout_pulse.sv
// Sector layout calculator and sector pulse generator for a disk drive.
// Assumes byteTick and indexPulse are one-cycle pulses synchronous to ref_clk.
// Summary of operation
// - Lower-capacity models get floor(24000 / (data + header + overhead)) sectors.
// - The largest model gets floor(32000 / (data + header + overhead)) sectors.
// - The sector count division discards any fraction.
// - The data length counts the check characters as well as the payload.
// - The first format adds 59 overhead bytes on the lower pair and 39 on the higher.
// - The second format adds 60 overhead bytes on the lower pair and 40 on the higher.
// - The third format adds 75 overhead bytes on the lower pair and 55 on the higher.
// - Without a sector-count command the switch setting picks the pulse count.
// - The switch count is the third-format count for the selected data field.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module disk_sector_layout_pulse #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Drive timing and switches.
  input wire logic byteTick,
  input wire logic indexPulse,
  input wire logic [1:0] sectorLengthSwitch,
  // Sector pulse to the controller.
  output logic sectorPulse
);

  typedef enum logic [1:0] {ST_IDLE, ST_LAYOUT, ST_SWITCH, ST_SPACING} dslp_state_t;

  dslp_state_t state_r;
  dslp_div_if #(.W(W)) divBus ();

  logic [1:0] model_r;
  logic [1:0] fmt_r;
  logic [W-1:0] dataLen_r;
  logic [W-1:0] hdrLen_r;
  logic [W-1:0] checkLen_r;
  logic [W-1:0] cmdCount_r;
  logic cmdValid_r;
  logic [W-1:0] layoutCount_r;
  logic [W-1:0] switchCount_r;
  logic [W-1:0] activeCount_r;
  logic [W-1:0] spacing_r;
  logic [W-1:0] bytePos_r;
  logic [W-1:0] nextMark_r;
  logic [W-1:0] pulsesLeft_r;
  logic [1:0] swPrev_r;
  logic recalc_r;
  logic divStart_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic sectorPulse_r;

  // Overhead by format and capacity pair.
  function automatic logic [W-1:0] formatOverheadBytes(input logic [1:0] fmt, input logic high);
    logic [15:0] v;
    v = high ? dslp_pkg::OVHD_F3_HIGH : dslp_pkg::OVHD_F3_LOW;
    if (fmt == dslp_pkg::FMT_ONE) begin
      v = high ? dslp_pkg::OVHD_F1_HIGH : dslp_pkg::OVHD_F1_LOW;
    end else if (fmt == dslp_pkg::FMT_TWO) begin
      v = high ? dslp_pkg::OVHD_F2_HIGH : dslp_pkg::OVHD_F2_LOW;
    end
    return W'(v);
  endfunction : formatOverheadBytes

  // Decode of the capacity pair, used by the first two divisions, and the byte budget, shared by all three.
  wire logic highPair = model_r[1];
  wire logic [W-1:0] budget = (model_r == dslp_pkg::MODEL_D) ? W'(dslp_pkg::BUDGET_LARGE)
                                                             : W'(dslp_pkg::BUDGET_STD);
  wire logic [W-1:0] layoutDiv = dataLen_r + hdrLen_r + formatOverheadBytes(fmt_r, highPair);
  wire logic [W-1:0] swData = W'(dslp_pkg::SW_BASE_DATA << sectorLengthSwitch);
  wire logic [W-1:0] switchDiv = swData + checkLen_r + hdrLen_r
                                 + formatOverheadBytes(dslp_pkg::FMT_THREE, highPair);
  wire logic [W-1:0] chosenCount = cmdValid_r ? cmdCount_r : switchCount_r;

  // Divider request: the divisor follows the current phase.
  assign divBus.start = divStart_r;
  assign divBus.dividend = budget;
  assign divBus.divisor = (state_r == ST_LAYOUT) ? layoutDiv
                        : (state_r == ST_SWITCH) ? switchDiv : chosenCount;

  dslp_divider #(.W(W)) uDiv (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .dv(divBus)
  );

  // APB decode; registers answer with one wait state.
  wire logic access = psel && penable && pready_r;
  wire logic wrEn = access && pwrite;
  wire logic mapped = paddr <= dslp_pkg::SPACING_OFS && paddr[1:0] == 2'h0;
  wire logic roHit = paddr == dslp_pkg::STATUS_OFS || paddr == dslp_pkg::SPACING_OFS;
  wire logic cfgWrite = wrEn && mapped && !roHit;
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      dslp_pkg::CTRL_OFS: rdMux = {28'h0, fmt_r, model_r};
      dslp_pkg::DATALEN_OFS: rdMux = 32'(dataLen_r);
      dslp_pkg::HDRLEN_OFS: rdMux = 32'(hdrLen_r);
      dslp_pkg::CHECKLEN_OFS: rdMux = 32'(checkLen_r);
      dslp_pkg::SECCMD_OFS: rdMux = {15'h0, cmdValid_r, 16'(cmdCount_r)};
      dslp_pkg::STATUS_OFS: rdMux = {16'(activeCount_r), 16'(layoutCount_r)};
      dslp_pkg::SPACING_OFS: rdMux = {16'(bytePos_r), 16'(spacing_r)};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Bus handshake and answer registers.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel && penable && !pready_r;
      prdata_r <= (psel && penable && !pready_r && !pwrite) ? rdMux : 32'h0000_0000;
      pslverr_r <= psel && penable && !pready_r && !mapped;
    end
  end

  // Software-writable configuration.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      model_r <= dslp_pkg::MODEL_RST;
      fmt_r <= dslp_pkg::FMT_RST;
      dataLen_r <= W'(dslp_pkg::DATALEN_RST);
      hdrLen_r <= W'(dslp_pkg::HDRLEN_RST);
      checkLen_r <= W'(dslp_pkg::CHECKLEN_RST);
      cmdCount_r <= '0;
      cmdValid_r <= 1'b0;
    end else if (cfgWrite) begin
      unique case (paddr)
        dslp_pkg::CTRL_OFS: begin
          model_r <= pwdata[dslp_pkg::CTRL_MODEL_LSB +: 2];
          fmt_r <= pwdata[dslp_pkg::CTRL_FMT_LSB +: 2];
        end
        dslp_pkg::DATALEN_OFS: dataLen_r <= pwdata[W-1:0];
        dslp_pkg::HDRLEN_OFS: hdrLen_r <= pwdata[W-1:0];
        dslp_pkg::CHECKLEN_OFS: checkLen_r <= pwdata[W-1:0];
        dslp_pkg::SECCMD_OFS: begin
          cmdCount_r <= pwdata[W-1:0];
          cmdValid_r <= pwdata[dslp_pkg::SECCMD_VALID_BIT];
        end
        default: cmdValid_r <= cmdValid_r;
      endcase
    end
  end

  // Recalculation request; a new cause in the start cycle keeps it pending.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      recalc_r <= 1'b1;
      swPrev_r <= 2'h0;
    end else begin
      swPrev_r <= sectorLengthSwitch;
      if (cfgWrite || swPrev_r != sectorLengthSwitch) begin
        recalc_r <= 1'b1;
      end else if (divStart_r && state_r == ST_LAYOUT) begin
        recalc_r <= 1'b0;
      end
    end
  end

  // Three chained divisions: layout count, switch count, then pulse spacing.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      divStart_r <= 1'b0;
      layoutCount_r <= '0;
      switchCount_r <= '0;
      activeCount_r <= '0;
      spacing_r <= '0;
    end else begin
      divStart_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: if (recalc_r) begin
          state_r <= ST_LAYOUT;
          divStart_r <= 1'b1;
        end
        ST_LAYOUT: if (divBus.done) begin
          layoutCount_r <= divBus.quotient;
          state_r <= ST_SWITCH;
          divStart_r <= 1'b1;
        end
        ST_SWITCH: if (divBus.done) begin
          switchCount_r <= divBus.quotient;
          state_r <= ST_SPACING;
          // Always start: the fresh switch count reaches chosenCount only next cycle,
          // so deciding on it here could leave this state waiting for a done that never comes.
          divStart_r <= 1'b1;
        end
        ST_SPACING: if (divBus.done) begin
          // A zero count would divide by zero, so it means no sector pulses.
          activeCount_r <= chosenCount;
          spacing_r <= (chosenCount == '0) ? '0 : divBus.quotient;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Byte position and sector marks; the first sector starts at index.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bytePos_r <= '0;
      nextMark_r <= '0;
      pulsesLeft_r <= '0;
      sectorPulse_r <= 1'b0;
    end else begin
      sectorPulse_r <= 1'b0;
      if (indexPulse) begin
        bytePos_r <= '0;
        nextMark_r <= spacing_r;
        pulsesLeft_r <= (activeCount_r == '0) ? '0 : activeCount_r - 1'b1;
        sectorPulse_r <= activeCount_r != '0;
      end else if (byteTick) begin
        bytePos_r <= bytePos_r + 1'b1;
        if (bytePos_r + 1'b1 == nextMark_r && pulsesLeft_r != '0) begin
          sectorPulse_r <= 1'b1;
          nextMark_r <= nextMark_r + spacing_r;
          pulsesLeft_r <= pulsesLeft_r - 1'b1;
        end
      end
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign sectorPulse = sectorPulse_r;

endmodule : disk_sector_layout_pulse
`default_nettype wire

//--- verif/dslp_monitor.sv
// Port checker for the sector layout block: bus answers and pulse causes.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dslp_monitor #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Track timing and pulse.
  input wire logic byteTick,
  input wire logic indexPulse,
  input wire logic sectorPulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Mapped places are word aligned and end at the spacing word.
  wire logic mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'h0);

  // An access starts, then exactly one wait state precedes ready.
  sequence sAccStart;
    psel && penable && $rose(penable);
  endsequence
  sequence sOneWait;
    !pready ##1 pready;
  endsequence

  AST_ONE_WAIT: assert property (sAccStart |-> sOneWait)
    else $error("ready not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  AST_ERR_UNMAPPED: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  // A pulse always follows an index or a byte tick by one cycle.
  AST_PULSE_CAUSE: assert property (sectorPulse |-> $past(indexPulse) || $past(byteTick))
    else $error("sector pulse without cause");
endmodule : dslp_monitor

bind disk_sector_layout_pulse dslp_monitor #(.W(W)) u_mon (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .byteTick(byteTick),
  .indexPulse(indexPulse), .sectorPulse(sectorPulse));
`default_nettype wire

//--- verif/dslp_track_model.sv
// Track model: spins the platter as index and byte ticks, counts sector pulses.
// Assumes the block samples its inputs on the rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module dslp_track_model (
  // Clock.
  input wire logic ref_clk,
  // Timing out, pulse in.
  output logic byteTick,
  output logic indexPulse,
  input wire logic sectorPulse
);
  // The platter is still until a revolution is asked for.
  initial begin
    byteTick = 1'b0;
    indexPulse = 1'b0;
  end

  // A priming index lets new spacing take hold, then the counted index.
  // Ticks stop at one track; room after the last sector is the pad.
  task automatic spin(input int bytes, output int pulses);
    pulses = 0;
    for (int i = 0; i < bytes + 6; i++) begin
      indexPulse <= (i == 0) || (i == 3);
      byteTick <= (i > 3) && (i < bytes + 4);
      @(posedge ref_clk);
      if (i > 3 && sectorPulse === 1'b1) begin
        pulses++;
      end
    end
  endtask : spin
endmodule : dslp_track_model
`default_nettype wire

//--- verif/tb_disk_sector_layout_pulse.sv
// Self-checking bench for the sector layout block.
// Assumes the checker and the track model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_disk_sector_layout_pulse;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] sectorLengthSwitch = 2'h0;
  logic pready, pslverr, byteTick, indexPulse, sectorPulse;
  logic [31:0] prdata, rd;
  logic err;
  int fail_count = 0;
  int num_checks = 0;
  int n;

  disk_sector_layout_pulse #(.W(16)) dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .byteTick(byteTick), .indexPulse(indexPulse),
    .sectorLengthSwitch(sectorLengthSwitch), .sectorPulse(sectorPulse));
  dslp_track_model u_trk (.ref_clk(ref_clk), .byteTick(byteTick),
    .indexPulse(indexPulse), .sectorPulse(sectorPulse));

  // Clock of 4 ns.
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer; the gap cycle after it keeps psel from being driven twice.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  // Sector count from the byte budget; integer division drops the fraction.
  function automatic logic [15:0] nsec(input int m, input int f, input int d);
    int ovhd;
    ovhd = (f == 0) ? 59 : (f == 1) ? 60 : 75;
    ovhd = (m < 2) ? ovhd : ovhd - 20;
    return 16'(((m == 3) ? 32000 : 24000) / (d + 8 + ovhd));
  endfunction : nsec

  task automatic t_reset;
    logic [31:0] exp [4] = '{32'h8, 32'd133, 32'd8, 32'd5};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, exp[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, {nsec(0, 2, 133), nsec(0, 2, 133)});
    $display("test reset done");
  endtask : t_reset

  task automatic t_formula;
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 4; f++) begin
        apb(1'b1, 8'h00, 32'(4 * f + m));
        repeat (60) @(posedge ref_clk);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, {nsec(m, 2, 133), nsec(m, f, 133)});
      end
    end
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h04, 32'd517);
    // The second write lands while the first chain runs, so two chains must finish.
    repeat (120) @(posedge ref_clk);
    apb(1'b0, 8'h14, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, nsec(0, 2, 517)});
    apb(1'b1, 8'h04, 32'd133);
    $display("test formula done");
  endtask : t_formula

  task automatic t_switch;
    for (int s = 0; s < 4; s++) begin
      sectorLengthSwitch <= 2'(s);
      repeat (60) @(posedge ref_clk);
      apb(1'b0, 8'h14, 32'h0);
      chk({16'h0, rd[31:16]}, {16'h0, nsec(0, 2, (128 << s) + 5)});
    end
    u_trk.spin(24000, n);
    chk(32'(n), 32'(nsec(0, 2, 1029)));
    apb(1'b0, 8'h18, 32'h0);
    chk({16'h0, rd[15:0]}, 32'(24000 / nsec(0, 2, 1029)));
    $display("test switch done");
  endtask : t_switch

  task automatic t_command;
    apb(1'b1, 8'h10, 32'h0001_0004);
    repeat (60) @(posedge ref_clk);
    u_trk.spin(24000, n);
    chk(32'(n), 32'd4);
    apb(1'b0, 8'h18, 32'h0);
    chk({16'h0, rd[15:0]}, 32'd6000);
    apb(1'b1, 8'h10, 32'h0);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, 8'h14, 32'h0);
    chk({16'h0, rd[31:16]}, 32'(nsec(0, 2, 1029)));
    $display("test command done");
  endtask : t_command

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_formula();
    t_switch();
    t_command();
    print_verdict();
  end

  // The run needs about 50000 cycles, so a hang is cut short well after that.
  initial begin
    repeat (70000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
endmodule : tb_disk_sector_layout_pulse
`default_nettype wire
